//--- hdl/rsdx_pkg.sv
// Shared constants and types for the operand decode and byte exchange block
package rsdx_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned MIN_TERM_CYC = 1;
	localparam int unsigned XCHG_ACCESSES = 2;

	// ---------------------------------------------------------------
	// Instruction set size
	// ---------------------------------------------------------------
	localparam int unsigned INSTR_SET_SIZE = 165;
	localparam int unsigned INSTR_GROUPS = 16;

	// ---------------------------------------------------------------
	// Field positions inside the 16-bit instruction word
	// ---------------------------------------------------------------
	localparam int unsigned RI_LSB = 0;
	localparam int unsigned RJ_LSB = 4;
	localparam int unsigned SUB_LSB = 4;
	localparam int unsigned OP_LSB = 8;
	localparam int unsigned I4_LSB = 4;
	localparam int unsigned I8_LSB = 4;
	localparam int unsigned LBL9_LSB = 0;
	localparam int unsigned LBL12_LSB = 0;
	localparam int unsigned NUM_GPR = 16;
	localparam logic [3:0] STACK_GPR = 4'hF;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {FMT_A, FMT_B, FMT_C, FMT_D, FMT_E, FMT_F} rsdx_fmt_type;
	typedef enum logic [1:0] {EXT_ZERO, EXT_ONES, EXT_SIGN} rsdx_ext_type;
	typedef enum logic [4:0] {
		SEL_I4_ZERO, SEL_I4_ONES, SEL_I8, SEL_I20, SEL_I32, SEL_S8, SEL_S10,
		SEL_U4, SEL_U8, SEL_U10, SEL_WORD_OFFSET_SHORT, SEL_DISP8, SEL_DISP9, SEL_DISP10,
		SEL_DIR8, SEL_DIR9, SEL_DIR10, SEL_LABEL9, SEL_PC_REL_TARGET_LONG
	} rsdx_opnd_type;
	typedef enum logic [2:0] {
		table_base_reg, return_pointer_reg, user_stack_ptr, system_stack_ptr,
		mul_div_high_reg, mul_div_low_reg
	} rsdx_dreg_type;
	typedef enum logic [1:0] {XB_IDLE, XB_READ, XB_WRITE} rsdx_xstate_type;

endpackage

//--- hdl/rsdx_ext.sv
// Zero, ones and sign extension of a field of variable width
`timescale 1ns/1ps
module rsdx_ext #(
	parameter int unsigned W = 32
) (
	input wire logic [W-1:0] raw_i,
	input wire logic [5:0] width_i,
	input wire rsdx_pkg::rsdx_ext_type mode_i,
	output logic [W-1:0] ext_o
);

	logic fill;
	logic [W-1:0] top_bit;

	// Fill bit chosen by mode; sign takes the field's top bit
	always_comb begin
		top_bit = raw_i >> (width_i - 6'd1);
		unique case (mode_i)
			rsdx_pkg::EXT_ZERO: fill = 1'b0; // [RULE_13]
			rsdx_pkg::EXT_ONES: fill = 1'b1; // [RULE_13]
			rsdx_pkg::EXT_SIGN: fill = top_bit[0]; // [RULE_13]
			default: fill = 1'b0;
		endcase
	end

	// Bits at or above the field width take the fill
	for (genvar b = 0; b < W; b++) begin : g_bit
		assign ext_o[b] = (b < width_i) ? raw_i[b] : fill;
	end

endmodule

//--- hdl/rsdx_core.sv
// Operand decode, interlock and byte exchange sequencer of the RISC core
//
// Contract
// [RULE_01] Exchange: low byte out, zero-extended byte in
// [RULE_02] Hold refused from exchange read to write
// [RULE_03] Exchange takes two accesses, flags kept
// [RULE_04] Four-bit immediate zero 0..15, ones -16..-1
// [RULE_05] Constant immediates unsigned over full range
// [RULE_06] s8 -128..127, s10 -512..508 step four
// [RULE_07] u10 stored divided by four, 0..1020
// [RULE_08] Short word offset 0..60 step four
// [RULE_09] Signed displacements byte, half, word scaled
// [RULE_10] Direct addresses byte, half, word scaled
// [RULE_11] Branch offsets signed even, nine and twelve
// [RULE_12] Sixteen general registers, six dedicated registers
// [RULE_13] Zero, ones and sign extension operators
// [RULE_14] Formats A C D eight-bit, B upper four
// [RULE_15] Format E op plus sub, F upper five
// [RULE_16] Every cycle term at least one, ready stretches
// [RULE_17] Load-use interlock raises step to two
// [RULE_18] Stack or format A follower adds one cycle
// [RULE_19] Instruction set of 165 in sixteen groups
// [RULE_20] Immediate loads clear upper bits
// [RULE_21] Undefined opcode patterns flagged
`timescale 1ns/1ps
module rsdx_core #(
	parameter logic [7:0] EXCH_OPCODE = 8'h8A
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [31:0] ext_word_i,
	input wire rsdx_pkg::rsdx_fmt_type format_i,
	input wire rsdx_pkg::rsdx_opnd_type operand_sel_i,
	input wire logic prev_is_load_i,
	input wire logic [3:0] prev_load_reg_i,
	input wire logic prev_c_term_i,
	input wire logic next_uses_sp_i,
	output logic dec_valid_o,
	output logic [7:0] opcode_o,
	output logic [3:0] secondary_opcode_field_o,
	output logic undefined_o,
	output logic is_exchange_o,
	output logic [3:0] reg_i_o,
	output logic [3:0] reg_j_o,
	output logic [2:0] dedicated_sel_o,
	output logic dedicated_ok_o,
	output logic [31:0] operand_o,
	output logic stall_o,
	input wire logic xchg_start_i,
	input wire logic [31:0] xchg_src_i,
	input wire logic [31:0] xchg_addr_i,
	output logic xchg_ready_o,
	output logic flags_hold_o,
	output logic [31:0] xchg_result_o,
	output logic xchg_result_we_o,
	output logic [7:0] xchg_cycles_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_ready_i,
	input wire logic hold_req_i,
	output logic hold_ack_o
);

	// ---------------------------------------------------------------
	// Opcode extraction per format
	// ---------------------------------------------------------------
	logic [7:0] op_d;
	logic [3:0] sub_d;
	localparam int unsigned OP_OFS = rsdx_pkg::OP_LSB;
	localparam int unsigned SUB_OFS = rsdx_pkg::SUB_LSB;

	// Opcode bits as each format places them
	always_comb begin
		op_d = instr_i[OP_OFS +: 8];
		sub_d = 4'h0;
		unique case (format_i)
			rsdx_pkg::FMT_A, rsdx_pkg::FMT_C, rsdx_pkg::FMT_D: begin
				op_d = instr_i[OP_OFS +: 8]; // [RULE_14]
			end
			rsdx_pkg::FMT_B: begin
				op_d = {instr_i[15:12], 4'h0}; // [RULE_14]
			end
			rsdx_pkg::FMT_E: begin
				op_d = instr_i[OP_OFS +: 8]; // [RULE_15]
				sub_d = instr_i[SUB_OFS +: 4]; // [RULE_15]
			end
			rsdx_pkg::FMT_F: begin
				op_d = {instr_i[15:11], 3'h0}; // [RULE_15]
			end
			default: op_d = instr_i[OP_OFS +: 8];
		endcase
	end

	// ---------------------------------------------------------------
	// Defined opcode table
	// ---------------------------------------------------------------
	// Only the groups this block knows are listed; anything else is
	// reported so the exception logic can trap it rather than guess.
	function automatic logic op_known(input rsdx_pkg::rsdx_fmt_type f,
		input logic [7:0] op, input logic [3:0] sub);
		logic ok;
		ok = 1'b0;
		unique case (f)
			rsdx_pkg::FMT_A: begin
				unique case (op)
					8'hA6, 8'hA7, 8'hA2, 8'hAC, 8'hAD, 8'hAE, 8'hAA,
					8'h82, 8'h84, 8'h85, 8'h86, 8'h92, 8'h94, 8'h95, 8'h96,
					8'h9A, 8'h9C, 8'h9D, 8'h9E, 8'hAF, 8'hAB, 8'hBF, 8'hBB,
					8'hB6, 8'hB2, 8'hBA: ok = 1'b1;
					default: ok = (op == EXCH_OPCODE);
				endcase
			end
			rsdx_pkg::FMT_C: begin
				unique case (op)
					8'hA4, 8'hA5, 8'hA0, 8'hA1, 8'hA8, 8'hA9, 8'h80, 8'h81,
					8'h90, 8'h91, 8'h98, 8'h99, 8'h88, 8'h89, 8'hB4, 8'hB5,
					8'hB0, 8'hB1, 8'hB8, 8'hB9, 8'h9B: ok = 1'b1;
					default: ok = 1'b0;
				endcase
			end
			rsdx_pkg::FMT_B: ok = (op == 8'hC0);
			rsdx_pkg::FMT_E: begin
				ok = (op == 8'h97 && sub >= 4'h4 && sub <= 4'h7) ||
					(op == 8'h9F && sub >= 4'h6 && sub <= 4'h8);
			end
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ---------------------------------------------------------------
	// Operand field selection
	// ---------------------------------------------------------------
	logic [31:0] raw;
	logic [5:0] fwidth;
	rsdx_pkg::rsdx_ext_type fmode;
	logic [1:0] fshift;
	logic [31:0] ext_val;

	// Raw field, width, fill and scale for each operand kind
	always_comb begin
		raw = {28'h0, instr_i[rsdx_pkg::I4_LSB +: 4]};
		fwidth = 6'd4;
		fmode = rsdx_pkg::EXT_ZERO;
		fshift = 2'd0;
		unique case (operand_sel_i)
			rsdx_pkg::SEL_I4_ZERO: fmode = rsdx_pkg::EXT_ZERO; // [RULE_04]
			rsdx_pkg::SEL_I4_ONES: fmode = rsdx_pkg::EXT_ONES; // [RULE_04]
			rsdx_pkg::SEL_U4: fmode = rsdx_pkg::EXT_ZERO;
			rsdx_pkg::SEL_I8, rsdx_pkg::SEL_U8, rsdx_pkg::SEL_DIR8: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_05] [RULE_10]
				fwidth = 6'd8; // [RULE_20]
			end
			rsdx_pkg::SEL_I20: begin
				raw = {12'h0, instr_i[rsdx_pkg::I4_LSB +: 4], ext_word_i[15:0]}; // [RULE_05]
				fwidth = 6'd20; // [RULE_20]
			end
			rsdx_pkg::SEL_I32: begin
				raw = ext_word_i; // [RULE_05]
				fwidth = 6'd32;
			end
			rsdx_pkg::SEL_S8, rsdx_pkg::SEL_DISP8: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_06] [RULE_09]
				fwidth = 6'd8;
				fmode = rsdx_pkg::EXT_SIGN;
			end
			rsdx_pkg::SEL_S10, rsdx_pkg::SEL_DISP10: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_06] [RULE_09]
				fwidth = 6'd8;
				fmode = rsdx_pkg::EXT_SIGN;
				fshift = 2'd2;
			end
			rsdx_pkg::SEL_DISP9: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_09]
				fwidth = 6'd8;
				fmode = rsdx_pkg::EXT_SIGN;
				fshift = 2'd1;
			end
			rsdx_pkg::SEL_U10, rsdx_pkg::SEL_DIR10: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_07] [RULE_10]
				fwidth = 6'd8;
				fshift = 2'd2;
			end
			rsdx_pkg::SEL_DIR9: begin
				raw = {24'h0, instr_i[rsdx_pkg::I8_LSB +: 8]}; // [RULE_10]
				fwidth = 6'd8;
				fshift = 2'd1;
			end
			rsdx_pkg::SEL_WORD_OFFSET_SHORT: begin
				raw = {28'h0, instr_i[rsdx_pkg::I4_LSB +: 4]}; // [RULE_08]
				fshift = 2'd2;
			end
			rsdx_pkg::SEL_LABEL9: begin
				raw = {24'h0, instr_i[rsdx_pkg::LBL9_LSB +: 8]}; // [RULE_11]
				fwidth = 6'd8;
				fmode = rsdx_pkg::EXT_SIGN;
				fshift = 2'd1;
			end
			rsdx_pkg::SEL_PC_REL_TARGET_LONG: begin
				raw = {21'h0, instr_i[rsdx_pkg::LBL12_LSB +: 11]}; // [RULE_11]
				fwidth = 6'd11;
				fmode = rsdx_pkg::EXT_SIGN;
				fshift = 2'd1;
			end
			default: fmode = rsdx_pkg::EXT_ZERO;
		endcase
	end

	rsdx_ext #(
		.W(32)
	) u_ext (
		.raw_i(raw),
		.width_i(fwidth),
		.mode_i(fmode),
		.ext_o(ext_val)
	);

	// ---------------------------------------------------------------
	// Registered decode results
	// ---------------------------------------------------------------
	// Scaling after extension keeps scaled fields multiples of 2 or 4
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			opcode_o <= rsdx_pkg::RST_BYTE;
			secondary_opcode_field_o <= 4'h0;
			undefined_o <= 1'b0;
			is_exchange_o <= 1'b0;
			reg_i_o <= 4'h0;
			reg_j_o <= 4'h0;
			dedicated_sel_o <= 3'h0;
			dedicated_ok_o <= 1'b0;
			operand_o <= rsdx_pkg::RST_WORD;
		end else if (instr_valid_i) begin
			opcode_o <= op_d;
			secondary_opcode_field_o <= sub_d;
			undefined_o <= !op_known(format_i, op_d, sub_d); // [RULE_21] [RULE_19]
			is_exchange_o <= (format_i == rsdx_pkg::FMT_A) && (op_d == EXCH_OPCODE);
			reg_i_o <= instr_i[rsdx_pkg::RI_LSB +: 4]; // [RULE_12]
			reg_j_o <= instr_i[rsdx_pkg::RJ_LSB +: 4]; // [RULE_12]
			dedicated_sel_o <= instr_i[rsdx_pkg::RJ_LSB +: 3];
			dedicated_ok_o <= (instr_i[rsdx_pkg::RJ_LSB +: 4] <= 4'(rsdx_pkg::mul_div_low_reg)); // [RULE_12]
			operand_o <= ext_val << fshift;
		end
	end

	// Decode strobe, one cycle after the instruction is taken
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dec_valid_o <= 1'b0;
		end else begin
			dec_valid_o <= instr_valid_i;
		end
	end

	// ---------------------------------------------------------------
	// Pipeline interlocks
	// ---------------------------------------------------------------
	// Both register fields are checked; this may stall an instruction
	// that ignores a field, trading a cycle for a smaller decoder.
	logic load_use;
	logic sp_follow;

	assign load_use = prev_is_load_i && (instr_i[rsdx_pkg::RI_LSB +: 4] == prev_load_reg_i ||
		instr_i[rsdx_pkg::RJ_LSB +: 4] == prev_load_reg_i);
	assign sp_follow = prev_c_term_i && (next_uses_sp_i || format_i == rsdx_pkg::FMT_A ||
		instr_i[rsdx_pkg::RI_LSB +: 4] == rsdx_pkg::STACK_GPR ||
		instr_i[rsdx_pkg::RJ_LSB +: 4] == rsdx_pkg::STACK_GPR);

	// One extra cycle turns the one-cycle step into two
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stall_o <= 1'b0;
		end else begin
			stall_o <= instr_valid_i && (load_use || sp_follow); // [RULE_17] [RULE_18]
		end
	end

	// ---------------------------------------------------------------
	// Hold request synchroniser
	// ---------------------------------------------------------------
	logic hold_s1_q;
	logic hold_s2_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_s1_q <= 1'b0;
			hold_s2_q <= 1'b0;
		end else begin
			hold_s1_q <= hold_req_i;
			hold_s2_q <= hold_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Byte exchange sequencer
	// ---------------------------------------------------------------
	rsdx_pkg::rsdx_xstate_type xstate_q;
	logic [7:0] temp_q;
	logic [7:0] cyc_q;
	logic start_take;

	assign xchg_ready_o = (xstate_q == rsdx_pkg::XB_IDLE) && !hold_ack_o;
	assign start_take = xchg_start_i && xchg_ready_o;
	assign mem_req_o = (xstate_q != rsdx_pkg::XB_IDLE);
	assign mem_we_o = (xstate_q == rsdx_pkg::XB_WRITE);
	assign flags_hold_o = (xstate_q != rsdx_pkg::XB_IDLE); // [RULE_03]
	assign mem_wdata_o = temp_q;

	// Read then write; each access lasts until ready, never under one cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xstate_q <= rsdx_pkg::XB_IDLE;
		end else begin
			unique case (xstate_q)
				rsdx_pkg::XB_IDLE: if (start_take) begin
					xstate_q <= rsdx_pkg::XB_READ;
				end
				rsdx_pkg::XB_READ: if (mem_ready_i) begin
					xstate_q <= rsdx_pkg::XB_WRITE; // [RULE_16]
				end
				rsdx_pkg::XB_WRITE: if (mem_ready_i) begin
					xstate_q <= rsdx_pkg::XB_IDLE; // [RULE_03]
				end
			endcase
		end
	end

	// Source byte kept aside before the register is overwritten
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			temp_q <= rsdx_pkg::RST_BYTE;
			mem_addr_o <= rsdx_pkg::RST_WORD;
		end else if (start_take) begin
			temp_q <= xchg_src_i[7:0]; // [RULE_01]
			mem_addr_o <= xchg_addr_i; // [RULE_01]
		end
	end

	// Loaded byte returned zero-extended, written once at the end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xchg_result_o <= rsdx_pkg::RST_WORD;
		end else if (xstate_q == rsdx_pkg::XB_READ && mem_ready_i) begin
			xchg_result_o <= {24'h0, mem_rdata_i}; // [RULE_01]
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xchg_result_we_o <= 1'b0;
		end else begin
			xchg_result_we_o <= (xstate_q == rsdx_pkg::XB_WRITE) && mem_ready_i;
		end
	end

	// Bus cycles spent, equal to twice the access term
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cyc_q <= 8'h00;
			xchg_cycles_o <= 8'h00;
		end else if (start_take) begin
			cyc_q <= 8'h00;
		end else if (mem_req_o) begin
			cyc_q <= cyc_q + 8'h01;
			if (mem_we_o && mem_ready_i) begin
				xchg_cycles_o <= cyc_q + 8'h01; // [RULE_03]
			end
		end
	end

	// Hold granted only while no exchange runs or starts
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_ack_o <= 1'b0;
		end else begin
			hold_ack_o <= hold_s2_q && (xstate_q == rsdx_pkg::XB_IDLE) && !start_take; // [RULE_02]
		end
	end

endmodule

//--- testbench/rsdx_core_sva.sv
// Port-level checks on the operand decode and byte exchange core
`timescale 1ns/1ps
module rsdx_core_sva (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [31:0] ext_word_i,
	input wire rsdx_pkg::rsdx_fmt_type format_i,
	input wire rsdx_pkg::rsdx_opnd_type operand_sel_i,
	input wire logic prev_is_load_i,
	input wire logic [3:0] prev_load_reg_i,
	input wire logic [7:0] opcode_o,
	input wire logic [3:0] secondary_opcode_field_o,
	input wire logic [31:0] operand_o,
	input wire logic stall_o,
	input wire logic xchg_start_i,
	input wire logic [31:0] xchg_addr_i,
	input wire logic xchg_ready_o,
	input wire logic flags_hold_o,
	input wire logic xchg_result_we_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic mem_ready_i,
	input wire logic hold_ack_o
);
	// ---------------------------------------------------------------
	// Decode and exchange properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Exchange bus phases
	sequence rd_s; mem_req_o && !mem_we_o; endsequence
	sequence wr_s; mem_req_o && mem_we_o; endsequence
	fmt_b_op_a: assert property (instr_valid_i && format_i == rsdx_pkg::FMT_B |=>
		opcode_o == {$past(instr_i[15:12]), 4'h0}) else $error("format B opcode wrong");
	fmt_e_sub_a: assert property (instr_valid_i && format_i == rsdx_pkg::FMT_E |=>
		opcode_o == $past(instr_i[15:8]) && secondary_opcode_field_o == $past(instr_i[7:4]))
		else $error("format E opcode wrong");
	fmt_f_op_a: assert property (instr_valid_i && format_i == rsdx_pkg::FMT_F |=>
		opcode_o == {$past(instr_i[15:11]), 3'h0}) else $error("format F opcode wrong");
	ones_ext_a: assert property (instr_valid_i && operand_sel_i == rsdx_pkg::SEL_I4_ONES |=>
		operand_o == {28'hFFFFFFF, $past(instr_i[7:4])}) else $error("ones fill wrong");
	u10_scale_a: assert property (instr_valid_i && operand_sel_i == rsdx_pkg::SEL_U10 |=>
		operand_o == {22'h0, $past(instr_i[11:4]), 2'h0}) else $error("u10 scale wrong");
	i20_clear_a: assert property (instr_valid_i && operand_sel_i == rsdx_pkg::SEL_I20 |=>
		operand_o == {12'h0, $past(instr_i[7:4]), $past(ext_word_i[15:0])})
		else $error("i20 upper bits not clear");
	label_even_a: assert property (instr_valid_i && operand_sel_i == rsdx_pkg::SEL_PC_REL_TARGET_LONG |=>
		operand_o[0] == 1'h0 && operand_o[31:11] == {21{$past(instr_i[10])}}
		&& operand_o[10:1] == $past(instr_i[9:0])) else $error("pc_rel_target_long offset wrong");
	load_use_a: assert property (instr_valid_i && prev_is_load_i
		&& prev_load_reg_i == instr_i[3:0] |=> stall_o) else $error("no load-use stall");
	bus_hold_a: assert property (mem_req_o |-> flags_hold_o && !hold_ack_o)
		else $error("hold granted or flags free during exchange");
	xchg_read_a: assert property (xchg_start_i && xchg_ready_o |=> rd_s ##0
		mem_addr_o == $past(xchg_addr_i)) else $error("exchange read missing");
	xchg_step_a: assert property (rd_s ##0 mem_ready_i |=> wr_s ##0 $stable(mem_addr_o))
		else $error("exchange write missing");
	xchg_done_a: assert property (wr_s ##0 mem_ready_i |=> !mem_req_o && xchg_result_we_o)
		else $error("exchange end wrong");
	wait_keep_a: assert property (mem_req_o && !mem_ready_i |=>
		mem_req_o && $stable(mem_we_o) && $stable(mem_addr_o)) else $error("wait not held");
endmodule

//--- testbench/rsdx_mem_model.sv
// Byte memory with wait states and a hold requester on the far side of the core
`timescale 1ns/1ps
module rsdx_mem_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [1:0] waits_i,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	output logic [7:0] mem_rdata_o,
	output logic mem_ready_o,
	input wire logic hold_want_i,
	output logic hold_req_o
);
	// ---------------------------------------------------------------
	// Memory side
	// ---------------------------------------------------------------
	logic [7:0] mem_q [256];
	logic [1:0] wait_q;
	logic [7:0] last_q;
	// Ready after the set wait count; data is junk unless ready
	assign mem_ready_o = mem_req_i && (wait_q == waits_i);
	assign mem_rdata_o = mem_ready_o ? mem_q[mem_addr_i[7:0]] : ~last_q;
	// Contents start as an address pattern so reads can be predicted
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wait_q <= 2'h0;
			last_q <= 8'h00;
			for (int k = 0; k < 256; k++) begin
				mem_q[k] <= 8'(k) ^ 8'hA5;
			end
		end else if (mem_ready_o) begin
			wait_q <= 2'h0;
			last_q <= mem_rdata_o;
			if (mem_we_i) begin
				mem_q[mem_addr_i[7:0]] <= mem_wdata_i;
			end
		end else if (mem_req_i) begin
			wait_q <= wait_q + 2'h1;
		end
	end
	// Request follows hold_want_i one cycle late, served or not; the core decides when to grant
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_req_o <= 1'h0;
		end else begin
			hold_req_o <= hold_want_i;
		end
	end
endmodule

//--- testbench/rsdx_core_test.sv
// Self-checking bench for the operand decode and byte exchange core
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin $display("[ERR] %s exp %h got %h", nm, ex, got); error_cnt++; end end
module rsdx_core_test;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic instr_valid_i = 1'h0;
	logic [15:0] instr_i = 16'h0000;
	logic [31:0] ext_word_i = 32'h8765FFFF;
	rsdx_pkg::rsdx_fmt_type format_i = rsdx_pkg::FMT_A;
	rsdx_pkg::rsdx_opnd_type operand_sel_i = rsdx_pkg::SEL_I8;
	logic prev_is_load_i = 1'h0;
	logic [3:0] prev_load_reg_i = 4'h0;
	logic prev_c_term_i = 1'h0;
	logic next_uses_sp_i = 1'h0;
	logic xchg_start_i = 1'h0;
	logic [31:0] xchg_src_i = 32'h0;
	logic [31:0] xchg_addr_i = 32'h40;
	logic [1:0] waits = 2'h0;
	logic hold_want = 1'h0;
	logic dec_valid_o, undefined_o, is_exchange_o, dedicated_ok_o, stall_o, mem_ready_i;
	logic [7:0] opcode_o, mem_wdata_o, mem_rdata_i, xchg_cycles_o;
	logic [3:0] secondary_opcode_field_o, reg_i_o, reg_j_o;
	logic [2:0] dedicated_sel_o;
	logic [31:0] operand_o, xchg_result_o, mem_addr_o;
	logic xchg_ready_o, flags_hold_o, xchg_result_we_o, mem_req_o, mem_we_o, hold_req_i, hold_ack_o;
	int error_cnt = 0;
	int checked = 0;
	rsdx_core i_dut (.*);
	rsdx_mem_model i_mem (.clk_i(clk_i), .rstn_i(rstn_i), .waits_i(waits), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_rdata_o(mem_rdata_i), .mem_ready_o(mem_ready_i), .hold_want_i(hold_want),
		.hold_req_o(hold_req_i));
	// 20 MHz clock
	initial forever #25 clk_i = ~clk_i;
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One instruction for one cycle; a gap cycle keeps valid from toggling twice
	task automatic dec(input rsdx_pkg::rsdx_fmt_type f, input rsdx_pkg::rsdx_opnd_type s,
		input logic [15:0] w);
		@(negedge clk_i);
		format_i = f;
		operand_sel_i = s;
		instr_i = w;
		instr_valid_i = 1'h1;
		@(negedge clk_i);
		instr_valid_i = 1'h0;
		`CHK("dec_valid", 1'h1, dec_valid_o)
	endtask
	task automatic opnd(input rsdx_pkg::rsdx_opnd_type s, input logic [15:0] w,
		input logic [31:0] ex);
		dec(rsdx_pkg::FMT_C, s, w);
		`CHK("operand", ex, operand_o)
	endtask
	task automatic sc_formats();
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'h9F85);
		`CHK("op_a", 8'h9F, opcode_o)
		dec(rsdx_pkg::FMT_B, rsdx_pkg::SEL_I8, 16'h9F85);
		`CHK("op_b", 8'h90, opcode_o)
		dec(rsdx_pkg::FMT_D, rsdx_pkg::SEL_I8, 16'h9F85);
		`CHK("op_d", 8'h9F, opcode_o)
		dec(rsdx_pkg::FMT_E, rsdx_pkg::SEL_I8, 16'h9F85);
		`CHK("op_e", {8'h9F, 4'h8}, {opcode_o, secondary_opcode_field_o})
		dec(rsdx_pkg::FMT_F, rsdx_pkg::SEL_I8, 16'h9F85);
		`CHK("op_f", 8'h98, opcode_o)
		@(negedge clk_i);
		`CHK("dec_pulse", 1'h0, dec_valid_o)
	endtask
	task automatic sc_operands();
		opnd(rsdx_pkg::SEL_I4_ZERO, 16'h00F0, 32'h0000000F);
		opnd(rsdx_pkg::SEL_I4_ONES, 16'h0000, 32'hFFFFFFF0);
		opnd(rsdx_pkg::SEL_U4, 16'h00F0, 32'h0000000F);
		opnd(rsdx_pkg::SEL_U8, 16'h0FF0, 32'h000000FF);
		opnd(rsdx_pkg::SEL_I8, 16'h0FF0, 32'h000000FF);
		opnd(rsdx_pkg::SEL_I20, 16'h00F0, 32'h000FFFFF);
		opnd(rsdx_pkg::SEL_I32, 16'h0000, 32'h8765FFFF);
		opnd(rsdx_pkg::SEL_S8, 16'h07F0, 32'h0000007F);
		opnd(rsdx_pkg::SEL_S8, 16'h0800, 32'hFFFFFF80);
		opnd(rsdx_pkg::SEL_S10, 16'h07F0, 32'h000001FC);
		opnd(rsdx_pkg::SEL_S10, 16'h0800, 32'hFFFFFE00);
		opnd(rsdx_pkg::SEL_U10, 16'h0FF0, 32'h000003FC);
		opnd(rsdx_pkg::SEL_WORD_OFFSET_SHORT, 16'h00F0, 32'h0000003C);
		opnd(rsdx_pkg::SEL_DISP8, 16'h0800, 32'hFFFFFF80);
		opnd(rsdx_pkg::SEL_DISP9, 16'h07F0, 32'h000000FE);
		opnd(rsdx_pkg::SEL_DISP10, 16'h07F0, 32'h000001FC);
		opnd(rsdx_pkg::SEL_DIR8, 16'h0FF0, 32'h000000FF);
		opnd(rsdx_pkg::SEL_DIR9, 16'h0FF0, 32'h000001FE);
		opnd(rsdx_pkg::SEL_DIR10, 16'h0FF0, 32'h000003FC);
		opnd(rsdx_pkg::SEL_LABEL9, 16'h0080, 32'hFFFFFF00);
		opnd(rsdx_pkg::SEL_PC_REL_TARGET_LONG, 16'h03FF, 32'h000007FE);
	endtask
	task automatic sc_regs();
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'h005A);
		`CHK("regs", {4'hA, 4'h5, 3'h5, 1'h1}, {reg_i_o, reg_j_o, dedicated_sel_o, dedicated_ok_o})
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'h006F);
		`CHK("dreg_bad", {4'hF, 1'h0}, {reg_i_o, dedicated_ok_o})
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'h8A10);
		`CHK("xchg_op", 2'h2, {is_exchange_o, undefined_o})
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'hA610);
		`CHK("add_op", 1'h0, undefined_o)
		dec(rsdx_pkg::FMT_D, rsdx_pkg::SEL_I8, 16'h0F00);
		`CHK("undef", 1'h1, undefined_o)
	endtask
	task automatic sc_interlock();
		prev_is_load_i = 1'h1;
		prev_load_reg_i = 4'h3;
		dec(rsdx_pkg::FMT_C, rsdx_pkg::SEL_I8, 16'h0003);
		`CHK("ld_use", 1'h1, stall_o)
		dec(rsdx_pkg::FMT_C, rsdx_pkg::SEL_I8, 16'h0024);
		`CHK("ld_other", 1'h0, stall_o)
		prev_is_load_i = 1'h0;
		prev_c_term_i = 1'h1;
		dec(rsdx_pkg::FMT_C, rsdx_pkg::SEL_I8, 16'h0024);
		`CHK("c_plain", 1'h0, stall_o)
		dec(rsdx_pkg::FMT_A, rsdx_pkg::SEL_I8, 16'h0024);
		`CHK("c_fmt_a", 1'h1, stall_o)
		dec(rsdx_pkg::FMT_C, rsdx_pkg::SEL_I8, 16'h00F2);
		`CHK("c_r15", 1'h1, stall_o)
		next_uses_sp_i = 1'h1;
		dec(rsdx_pkg::FMT_C, rsdx_pkg::SEL_I8, 16'h0024);
		`CHK("c_sp", 1'h1, stall_o)
		@(negedge clk_i);
		`CHK("stall_pulse", 1'h0, stall_o)
		prev_c_term_i = 1'h0;
		next_uses_sp_i = 1'h0;
	endtask
	// One exchange at 0x40 with w wait states per access
	task automatic xchg(input logic [1:0] w, input logic [31:0] src, input logic [7:0] exp);
		int n;
		waits = w;
		@(negedge clk_i);
		xchg_src_i = src;
		xchg_start_i = 1'h1;
		`CHK("ready", 1'h1, xchg_ready_o)
		@(negedge clk_i);
		xchg_start_i = 1'h0;
		for (n = 0; n < 40 && xchg_result_we_o !== 1'h1; n++) begin
			`CHK("flags_hold", 1'h1, flags_hold_o)
			if (mem_we_o === 1'h1) `CHK("wdata", src[7:0], mem_wdata_o)
			@(negedge clk_i);
		end
		if (n == 40) begin
			error_cnt++;
			report_and_stop();
		end
		`CHK("result", {24'h0, exp}, xchg_result_o)
		`CHK("cycles", {5'h0, w, 1'h0} + 8'h2, xchg_cycles_o)
	endtask
	// Hold asked during an exchange is granted only once it is over
	task automatic sc_hold();
		int n;
		@(negedge clk_i);
		hold_want = 1'h1;
		xchg(2'h1, 32'h0000005A, 8'h00);
		for (n = 0; n < 8 && hold_ack_o !== 1'h1; n++) @(negedge clk_i);
		`CHK("hold_ack", 1'h1, hold_ack_o)
		xchg_start_i = 1'h1;
		@(negedge clk_i);
		xchg_start_i = 1'h0;
		`CHK("refused", 2'h0, {xchg_ready_o, mem_req_o})
		hold_want = 1'h0;
		for (n = 0; n < 8 && xchg_ready_o !== 1'h1; n++) @(negedge clk_i);
		`CHK("ack_drop", 2'h2, {xchg_ready_o, hold_ack_o})
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clk_i);
		rstn_i = 1'h1;
		@(negedge clk_i);
		`CHK("rst_idle", 3'h4, {xchg_ready_o, dec_valid_o, hold_ack_o})
		sc_formats();
		sc_operands();
		sc_regs();
		sc_interlock();
		xchg(2'h0, 32'h123456C3, 8'hE5);
		xchg(2'h2, 32'hFFFFFF3C, 8'hC3);
		xchg(2'h1, 32'h00000000, 8'h3C);
		sc_hold();
		report_and_stop();
	end
endmodule
bind rsdx_core rsdx_core_sva i_sva (.*);
